/* verilog/lmssc_pkg.sv */
package lmssc_pkg;

    // channel count and serial frame layout
    localparam int NCH = 4;
    localparam int AW = 6;
    localparam int DW = 8;
    localparam logic [4:0] HDR_CNT = 5'h08;
    localparam logic [4:0] LAST_CNT = 5'h0f;
    localparam logic [4:0] FRAME_CNT = 5'h10;
    localparam int F_RW = 7;
    localparam int F_ADDR_HI = 6;
    localparam int F_ADDR_LO = 1;

    // device register map
    localparam logic [5:0] ADDR_GLOBAL = 6'h00;
    localparam logic [5:0] ADDR_INT_STAT = 6'h01;
    localparam logic [5:0] ADDR_CHAN0 = 6'h02;
    localparam logic [7:0] GLOBAL_RST = 8'h00;
    localparam logic [7:0] CHAN_RST = 8'h00;
    localparam int G_SINGLE = 0;
    localparam int G_JPATH = 1;
    localparam int G_JLO = 2;
    localparam int G_JHI = 3;
    localparam int C_EURO = 0;
    localparam int C_SONET = 1;
    localparam int C_IE = 2;

    // controller register map
    localparam logic [1:0] H_CMD = 2'h0;
    localparam logic [1:0] H_DATA = 2'h1;
    localparam logic [1:0] H_STAT = 2'h2;
    localparam int H_CMD_RD = 7;
    localparam int S_BUSY = 0;
    localparam int S_IRQ = 1;
    localparam int SCLK_HALF_DEF = 8;
    localparam int SCLK_HALF_MIN = 8;

    typedef enum logic [1:0] {
        RATE_DS3 = 2'b00,
        RATE_STS1 = 2'b01,
        RATE_E3 = 2'b10
    } lmssc_rate_e;

    typedef enum logic [1:0] {
        JA_FIFO16 = 2'b00,
        JA_FIFO32 = 2'b01,
        JA_OFF = 2'b10
    } lmssc_ja_e;

    // euro select wins over sonet select
    function automatic lmssc_rate_e rate_decode(input logic euro,
                                                input logic sonet);
        if (euro)
            return RATE_E3;
        return sonet ? RATE_STS1 : RATE_DS3;
    endfunction

    // low select high disables, else high select picks depth
    function automatic lmssc_ja_e ja_decode(input logic lo, input logic hi);
        if (lo)
            return JA_OFF;
        return hi ? JA_FIFO32 : JA_FIFO16;
    endfunction

endpackage

/* verilog/lmssc_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface lmssc_if;
    logic cs_n;
    logic sclk;
    logic port_serial_in;
    logic sdo_d;
    logic sdo_oe;
    logic intr_d;
    logic intr_oe;
    logic port_serial_out;
    logic intr_n;

    // wire levels: data out pulled low, interrupt pulled high
    assign port_serial_out = sdo_oe ? sdo_d : 1'b0;
    assign intr_n = intr_oe ? intr_d : 1'b1;

    modport dev (
        input cs_n, sclk, port_serial_in, port_serial_out, intr_n,
        output sdo_d, sdo_oe, intr_d, intr_oe
    );
    modport host (
        output cs_n, sclk, port_serial_in,
        input port_serial_out, intr_n
    );
endinterface

`default_nettype wire

/* verilog/lmssc_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module lmssc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);
    logic [W-1:0] meta_q;

    // two-flop synchroniser, first stage read only by the second
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            meta_q <= INIT;
            Q <= INIT;
        end
        else
        begin
            meta_q <= D;
            Q <= meta_q;
        end
    end
endmodule // lmssc_sync

`default_nettype wire

/* verilog/lmssc_dev.sv */
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module lmssc_dev #(
    parameter int NCH = lmssc_pkg::NCH
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic MODE_SEL,
    input wire logic [NCH-1:0] EURO_SEL,
    input wire logic [NCH-1:0] SONET_SEL,
    input wire logic RAIL_SEL,
    input wire logic JA_SEL_LO,
    input wire logic JA_SEL_HI,
    input wire logic JA_PATH_SEL,
    input wire logic REG_RESET_N,
    input wire logic [NCH-1:0] LINE_LOSS,
    lmssc_if.dev LINK,
    output logic [2*NCH-1:0] CH_RATE,
    output logic SINGLE_RAIL,
    output logic CODEC_EN,
    output logic [1:0] JA_MODE,
    output logic JA_TX_PATH,
    output logic HOST_MODE,
    output logic RX_CLK_INV,
    output logic TX_CLK_INV,
    output logic RX_ENABLE,
    output logic RX_MON,
    output logic LOS_MUTE
);
    localparam int PW = 3 * NCH + 11;

    if (NCH < 1 || NCH > 8)
    begin : g_bad_nch
        $error("NCH must be 1 to 8");
    end

    // map address to channel index, -1 when not a channel register
    function automatic int chan_of(input logic [5:0] a);
        int idx;
        idx = int'(a) - int'(lmssc_pkg::ADDR_CHAN0);
        if (idx >= 0 && idx < NCH)
            return idx;
        return -1;
    endfunction

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_s;
    logic [NCH-1:0] euro_s, sonet_s, loss_s;
    logic host_s, rail_s, jlo_s, jhi_s, jpath_s, rstn_s;
    logic cs_n_s, sclk_s, sdi_s, sdo_s, intr_s;
    logic sclk_prev_q;
    logic [NCH-1:0] loss_prev_q;
    logic rise, fall, active, reg_rst;
    logic [4:0] cnt_q;
    logic [15:0] shift_q;
    logic [7:0] out_q;
    logic oe_q;
    logic intr_q;
    logic [7:0] global_q;
    logic [7:0] chan_q [NCH];
    logic [NCH-1:0] stat_q;
    logic [NCH-1:0] ie;
    logic [NCH-1:0] clr;
    logic wr_commit;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [5:0] raddr;

    assign pin_raw = {LINK.intr_n, LINK.port_serial_out, LINK.port_serial_in, LINK.sclk,
                      LINK.cs_n, REG_RESET_N, JA_PATH_SEL, JA_SEL_HI,
                      JA_SEL_LO, RAIL_SEL, MODE_SEL, LINE_LOSS, SONET_SEL,
                      EURO_SEL};

    // every pin passes two flops first
    lmssc_sync #(
        .W(PW),
        .INIT({1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, {(PW-6){1'b0}}})
    ) u_sync (
        .CLK(CLK),
        .RST(RST),
        .D(pin_raw),
        .Q(pin_s)
    );

    assign euro_s = pin_s[NCH-1:0];
    assign sonet_s = pin_s[2*NCH-1:NCH];
    assign loss_s = pin_s[3*NCH-1:2*NCH];
    assign {intr_s, sdo_s, sdi_s, sclk_s, cs_n_s, rstn_s, jpath_s, jhi_s,
            jlo_s, rail_s, host_s} = pin_s[PW-1:3*NCH];

    // edge finding on the synchronised pins
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sclk_prev_q <= 1'b0;
            loss_prev_q <= '0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            loss_prev_q <= loss_s;
        end
    end

    assign rise = sclk_s & ~sclk_prev_q;
    assign fall = ~sclk_s & sclk_prev_q;
    assign active = host_s & ~cs_n_s;
    assign reg_rst = RST | ~rstn_s;

    // frame bit counter and input shifter
    always_ff @(posedge CLK)
    begin
        if (RST || !active)
        begin
            cnt_q <= '0;
            shift_q <= '0;
        end
        else if (rise && cnt_q != lmssc_pkg::FRAME_CNT)
        begin
            shift_q <= {shift_q[14:0], sdi_s};
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // write lands on the sixteenth rise
    assign wr_commit = active & rise & (cnt_q == lmssc_pkg::LAST_CNT)
                       & ~shift_q[lmssc_pkg::F_RW + 7];
    assign waddr = shift_q[lmssc_pkg::F_ADDR_HI + 7:lmssc_pkg::F_ADDR_LO + 7];
    assign wdata = {shift_q[6:0], sdi_s};
    assign raddr = shift_q[lmssc_pkg::F_ADDR_HI:lmssc_pkg::F_ADDR_LO];

    // global control register
    always_ff @(posedge CLK)
    begin
        if (reg_rst)
            global_q <= lmssc_pkg::GLOBAL_RST;
        else if (wr_commit && waddr == lmssc_pkg::ADDR_GLOBAL)
            global_q <= wdata;
    end

    // per-channel control registers
    always_ff @(posedge CLK)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (reg_rst)
                chan_q[i] <= lmssc_pkg::CHAN_RST;
            else if (wr_commit && chan_of(waddr) == i)
                chan_q[i] <= wdata;
        end
    end

    // sticky loss events, write one to clear, set wins
    assign clr = (wr_commit && waddr == lmssc_pkg::ADDR_INT_STAT) ?
                 wdata[NCH-1:0] : '0;
    always_ff @(posedge CLK)
    begin
        if (reg_rst)
            stat_q <= '0;
        else
            stat_q <= (stat_q & ~clr) | (loss_s & ~loss_prev_q);
    end

    // interrupt enables from channel registers
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
            ie[i] = chan_q[i][lmssc_pkg::C_IE];
    end

    // active-low interrupt, only driven in host mode
    always_ff @(posedge CLK)
    begin
        if (RST)
            intr_q <= 1'b1;
        else
            intr_q <= ~|(stat_q & ie);
    end
    assign LINK.intr_d = intr_q;
    assign LINK.intr_oe = host_s;

    // read data shifter driven on falling edges
    always_ff @(posedge CLK)
    begin
        if (RST || !active)
        begin
            out_q <= '0;
            oe_q <= 1'b0;
        end
        else if (fall)
        begin
            if (cnt_q == lmssc_pkg::HDR_CNT && shift_q[lmssc_pkg::F_RW])
            begin
                oe_q <= 1'b1;
                if (raddr == lmssc_pkg::ADDR_GLOBAL)
                    out_q <= global_q;
                else if (raddr == lmssc_pkg::ADDR_INT_STAT)
                    out_q <= 8'(stat_q);
                else if (chan_of(raddr) >= 0)
                    out_q <= chan_q[chan_of(raddr)];
                else
                    out_q <= 8'h00;
            end
            else if (cnt_q == lmssc_pkg::FRAME_CNT)
                oe_q <= 1'b0;
            else if (oe_q)
                out_q <= {out_q[6:0], 1'b0};
        end
    end
    assign LINK.sdo_d = out_q[7];
    assign LINK.sdo_oe = oe_q;

    // operating configuration, from registers or from straps
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            CH_RATE <= '0;
            SINGLE_RAIL <= 1'b0;
            JA_MODE <= lmssc_pkg::JA_FIFO16;
            JA_TX_PATH <= 1'b0;
        end
        else if (host_s)
        begin
            for (int i = 0; i < NCH; i++)
                CH_RATE[2*i +: 2] <= lmssc_pkg::rate_decode(
                    chan_q[i][lmssc_pkg::C_EURO],
                    chan_q[i][lmssc_pkg::C_SONET]);
            SINGLE_RAIL <= global_q[lmssc_pkg::G_SINGLE];
            JA_MODE <= lmssc_pkg::ja_decode(global_q[lmssc_pkg::G_JLO],
                                            global_q[lmssc_pkg::G_JHI]);
            JA_TX_PATH <= global_q[lmssc_pkg::G_JPATH];
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
                CH_RATE[2*i +: 2] <= lmssc_pkg::rate_decode(
                    euro_s[i], sonet_s[i]);
            SINGLE_RAIL <= rail_s;
            JA_MODE <= lmssc_pkg::ja_decode(jlo_s, jhi_s);
            JA_TX_PATH <= jpath_s;
        end
    end
    assign CODEC_EN = SINGLE_RAIL;

    // port pins take their strap roles in hardware mode
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            HOST_MODE <= 1'b0;
            RX_CLK_INV <= 1'b0;
            TX_CLK_INV <= 1'b0;
            RX_ENABLE <= 1'b0;
            RX_MON <= 1'b0;
            LOS_MUTE <= 1'b0;
        end
        else
        begin
            HOST_MODE <= host_s;
            RX_CLK_INV <= ~host_s & cs_n_s;
            TX_CLK_INV <= ~host_s & sclk_s;
            RX_ENABLE <= ~host_s & sdi_s;
            RX_MON <= ~host_s & sdo_s;
            LOS_MUTE <= ~host_s & intr_s;
        end
    end
endmodule // lmssc_dev

`default_nettype wire

/* verilog/lmssc_host.sv */
`timescale 1ns/1ns
`default_nettype none

module lmssc_host #(
    parameter int SCLK_HALF = lmssc_pkg::SCLK_HALF_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    lmssc_if.host LINK
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW = 2'b01,
        H_HIGH = 2'b10,
        H_END = 2'b11
    } lmssc_hst_e;

    if (SCLK_HALF < lmssc_pkg::SCLK_HALF_MIN || SCLK_HALF > 255)
    begin : g_bad_half
        $error("SCLK_HALF must be 8 to 255");
    end

    lmssc_hst_e state_q;
    logic [7:0] div_q;
    logic [4:0] cnt_q;
    logic [15:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] data_q;
    logic cs_n_q, sclk_q;
    logic [1:0] in_s;
    logic sdo_s, irq_s;
    logic half_done, start;
    logic rx_read_q;

    // returning pins pass two flops
    lmssc_sync #(
        .W(2),
        .INIT(2'b10)
    ) u_sync (
        .CLK(CLK),
        .RST(RST),
        .D({LINK.intr_n, LINK.port_serial_out}),
        .Q(in_s)
    );
    assign {irq_s, sdo_s} = {~in_s[1], in_s[0]};

    assign half_done = (div_q == 8'(SCLK_HALF - 1));
    assign start = REG_WR && REG_ADDR == lmssc_pkg::H_CMD
                   && state_q == H_IDLE;

    // frame sequencer: chip select low, sixteen clocks, release
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_q <= H_IDLE;
            div_q <= '0;
            cnt_q <= '0;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            tx_q <= '0;
            rx_q <= '0;
        end
        else
        begin
            div_q <= half_done ? 8'h00 : div_q + 8'h01;
            case (state_q)
                H_IDLE:
                begin
                    div_q <= '0;
                    if (start)
                    begin
                        tx_q <= {REG_WDATA[lmssc_pkg::H_CMD_RD],
                                 REG_WDATA[5:0], 1'b0, data_q};
                        cnt_q <= '0;
                        cs_n_q <= 1'b0;
                        state_q <= H_LOW;
                    end
                end
                H_LOW:
                    if (half_done)
                    begin
                        sclk_q <= 1'b1;
                        if (cnt_q >= lmssc_pkg::HDR_CNT)
                            rx_q <= {rx_q[6:0], sdo_s};
                        cnt_q <= cnt_q + 5'h01;
                        state_q <= H_HIGH;
                    end
                H_HIGH:
                    if (half_done)
                    begin
                        sclk_q <= 1'b0;
                        tx_q <= {tx_q[14:0], 1'b0};
                        state_q <= (cnt_q == lmssc_pkg::FRAME_CNT) ?
                                   H_END : H_LOW;
                    end
                H_END:
                    if (half_done)
                    begin
                        cs_n_q <= 1'b1;
                        state_q <= H_IDLE;
                    end
                default:
                    state_q <= H_IDLE;
            endcase
        end
    end

    assign LINK.cs_n = cs_n_q;
    assign LINK.sclk = sclk_q;
    assign LINK.port_serial_in = tx_q[15];

    // data register: write value or last read result
    always_ff @(posedge CLK)
    begin
        if (RST)
            data_q <= '0;
        else if (state_q == H_END && half_done && cs_n_q == 1'b0
                 && rx_read_q)
            data_q <= rx_q;
        else if (REG_WR && REG_ADDR == lmssc_pkg::H_DATA)
            data_q <= REG_WDATA;
    end

    // remember whether the running frame is a read
    always_ff @(posedge CLK)
    begin
        if (RST)
            rx_read_q <= 1'b0;
        else if (start)
            rx_read_q <= REG_WDATA[lmssc_pkg::H_CMD_RD];
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge CLK)
    begin
        if (RST)
            REG_RDATA <= '0;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                lmssc_pkg::H_DATA:
                    REG_RDATA <= data_q;
                lmssc_pkg::H_STAT:
                    REG_RDATA <= {6'h00, irq_s, state_q != H_IDLE};
                default:
                    REG_RDATA <= 8'h00;
            endcase
        end
        else
            REG_RDATA <= '0;
    end
endmodule // lmssc_host

`default_nettype wire

/* verif/lmssc_sva.sv */
`timescale 1ns/1ns
`default_nettype none

module lmssc_sva (
    input wire logic CLK,
    input wire logic RST,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic port_serial_in,
    input wire logic sdo_d,
    input wire logic sdo_oe,
    input wire logic intr_d,
    input wire logic intr_oe
);
    logic sclk_q;
    logic [4:0] rise_q;
    logic [7:0] idle_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // rising serial clock edges seen in the current frame
    always_ff @(posedge CLK)
    begin
        sclk_q <= sclk;
        if (RST || cs_n)
            rise_q <= 5'h00;
        else if (sclk && !sclk_q)
            rise_q <= rise_q + 5'h01;
    end

    // cycles since chip select was last low, saturating
    always_ff @(posedge CLK)
    begin
        if (RST || !cs_n)
            idle_q <= 8'h00;
        else if (idle_q != 8'hff)
            idle_q <= idle_q + 8'h01;
    end

    // one high phase of the serial clock
    sequence s_high_phase;
        sclk [*8] ##1 !sclk;
    endsequence
    // frame closes after sixteen rises with output released
    sequence s_frame_done;
        (rise_q == 5'h10) ##0 !sdo_oe;
    endsequence

    chk_sclk_half: assert property ($rose(sclk) |-> s_high_phase)
        else $error("serial clock high phase has wrong length");
    chk_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("serial clock moved outside a frame");
    chk_sdi_hold: assert property (sclk |-> $stable(port_serial_in))
        else $error("serial input changed while clock high");
    chk_sdo_fall: assert property (sclk && $past(sclk) && sdo_oe
        && $past(sdo_oe) |-> $stable(sdo_d))
        else $error("serial output changed while clock high");
    chk_load_low: assert property ($rose(sdo_oe)
        |-> !cs_n && !sclk && rise_q == 5'h08)
        else $error("read data driven at wrong point");
    chk_sdo_range: assert property (sdo_oe |-> rise_q >= 5'h08)
        else $error("serial output driven before address phase ended");
    chk_frame_len: assert property ($rose(cs_n) |-> s_frame_done)
        else $error("frame length or output release wrong");
    chk_oe_idle: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("serial output driven while deselected");
    chk_intr_hold: assert property (intr_oe && !intr_d
        && idle_q >= 8'h14 |=> !intr_d)
        else $error("interrupt released without service");
endmodule // lmssc_sva

`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode_sel = 1'b0;
    logic rail_sel = 1'b0;
    logic ja_lo = 1'b0;
    logic ja_hi = 1'b0;
    logic ja_path = 1'b0;
    logic reg_reset_n = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] euro_sel = 4'h0;
    logic [3:0] sonet_sel = 4'h0;
    logic [3:0] line_loss = 4'h0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, ch_rate, rd_q;
    logic [1:0] ja_mode;
    logic single_rail, codec_en, ja_tx_path, host_mode;
    wire [4:0] roles;
    logic [7:0] chv [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
    int failures = 0;
    int samples_checked = 0;

    lmssc_if link ();

    lmssc_dev i_lmssc_dev (
        .CLK(clk), .RST(rst), .MODE_SEL(mode_sel), .EURO_SEL(euro_sel),
        .SONET_SEL(sonet_sel), .RAIL_SEL(rail_sel), .JA_SEL_LO(ja_lo),
        .JA_SEL_HI(ja_hi), .JA_PATH_SEL(ja_path),
        .REG_RESET_N(reg_reset_n), .LINE_LOSS(line_loss), .LINK(link.dev),
        .CH_RATE(ch_rate), .SINGLE_RAIL(single_rail), .CODEC_EN(codec_en),
        .JA_MODE(ja_mode), .JA_TX_PATH(ja_tx_path), .HOST_MODE(host_mode),
        .RX_CLK_INV(roles[4]), .TX_CLK_INV(roles[3]), .RX_ENABLE(roles[2]),
        .RX_MON(roles[1]), .LOS_MUTE(roles[0])
    );

    lmssc_host #(.SCLK_HALF(8)) i_lmssc_host (
        .CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .LINK(link.host)
    );

    lmssc_sva i_lmssc_sva (
        .CLK(clk), .RST(rst), .cs_n(link.cs_n), .sclk(link.sclk),
        .port_serial_in(link.port_serial_in), .sdo_d(link.sdo_d), .sdo_oe(link.sdo_oe),
        .intr_d(link.intr_d), .intr_oe(link.intr_oe)
    );

    // free-running system clock
    always #50 clk = ~clk;

    // compare and count
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic report_and_stop;
        $display("failures %0d samples_checked %0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one-cycle register port strobes
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask

    // poll busy with a bound
    task automatic wait_idle;
        int n;
        logic [7:0] s;
        cyc(2);
        for (n = 0; n < 300; n++)
        begin
            rd(lmssc_pkg::H_STAT, s);
            if (s[0] === 1'b0)
                break;
        end
        if (n == 300)
        begin
            failures++;
            report_and_stop();
        end
    endtask

    // device write and read frames
    task automatic dwr(input logic [5:0] a, input logic [7:0] d);
        wr(lmssc_pkg::H_DATA, d);
        wr(lmssc_pkg::H_CMD, {2'b00, a});
        wait_idle();
    endtask

    task automatic drd(input logic [5:0] a, output logic [7:0] d);
        wr(lmssc_pkg::H_CMD, {2'b10, a});
        wait_idle();
        rd(lmssc_pkg::H_DATA, d);
    endtask

    // strap decoding in hardware mode
    task automatic t_hw_straps;
        int j;
        logic [7:0] ja_exp;
        logic [7:0] rail_exp;
        mode_sel <= 1'b0;
        euro_sel <= 4'h3;
        sonet_sel <= 4'h5;
        cyc(8);
        check("host_mode", {7'h0, host_mode}, 8'h00);
        check("rate_a", ch_rate, 8'h1a);
        euro_sel <= 4'hc;
        sonet_sel <= 4'ha;
        cyc(8);
        check("rate_b", ch_rate, 8'ha4);
        for (j = 0; j < 4; j++)
        begin
            {ja_hi, ja_lo} <= 2'(j);
            rail_sel <= j[0]; // no negative rail data is driven
            ja_path <= j[1];
            ja_exp = j[0] ? 8'h02 : {7'h0, j[1]};
            rail_exp = {6'h0, {2{j[0]}}};
            cyc(8);
            check("ja_mode", {6'h0, ja_mode}, ja_exp);
            check("rail", {6'h0, single_rail, codec_en}, rail_exp);
            check("ja_path", {7'h0, ja_tx_path}, {7'h0, j[1]});
        end
        check("roles_idle", {3'h0, roles}, 8'h11);
    endtask

    // port traffic in hardware mode only moves the other roles
    task automatic t_hw_frame;
        wr(lmssc_pkg::H_DATA, 8'h0b);
        wr(lmssc_pkg::H_CMD, 8'h00);
        cyc(7);
        check("roles_frame", {3'h0, roles}, 8'h01);
        wait_idle();
    endtask

    // configuration through registers in host mode
    task automatic t_host_regs;
        int i;
        mode_sel <= 1'b1;
        rail_sel <= 1'b1;
        euro_sel <= 4'hf;
        cyc(8);
        check("host_mode", {7'h0, host_mode}, 8'h01);
        check("rate_host", ch_rate, 8'h00);
        check("rail_host", {6'h0, single_rail, codec_en}, 8'h00);
        dwr(6'h00, 8'h0b);
        for (i = 0; i < 4; i++)
            dwr(6'(lmssc_pkg::ADDR_CHAN0 + i), chv[i]);
        cyc(4);
        check("rate_reg", ch_rate, 8'h26);
        check("rail_reg", {6'h0, single_rail, codec_en}, 8'h03);
        check("ja_reg", {5'h0, ja_tx_path, ja_mode}, 8'h05);
        for (i = 0; i < 4; i++)
        begin
            drd(6'(lmssc_pkg::ADDR_CHAN0 + i), rd_q);
            check("chan_rd", rd_q, chv[i]);
        end
        drd(6'h3f, rd_q);
        check("unmapped_rd", rd_q, 8'h00);
        rd(2'h3, rd_q);
        check("host_unmapped", rd_q, 8'h00);
    endtask

    // loss event, hold until cleared, enable off
    task automatic t_interrupt;
        dwr(6'h02, 8'h04);
        dwr(6'h03, 8'h00);
        line_loss <= 4'h1;
        cyc(10);
        check("intr_low", {7'h0, link.intr_n}, 8'h00);
        rd(lmssc_pkg::H_STAT, rd_q);
        check("stat_irq", {7'h0, rd_q[1]}, 8'h01);
        cyc(40);
        drd(6'h01, rd_q);
        check("int_stat", rd_q, 8'h01);
        check("intr_held", {7'h0, link.intr_n}, 8'h00);
        dwr(6'h01, 8'h01);
        cyc(6);
        check("intr_clear", {7'h0, link.intr_n}, 8'h01);
        line_loss <= 4'h3;
        cyc(10);
        check("intr_masked", {7'h0, link.intr_n}, 8'h01);
        drd(6'h01, rd_q);
        check("int_stat_m", rd_q, 8'h02);
        dwr(6'h01, 8'h02);
        line_loss <= 4'h0;
    endtask

    // register reset restores defaults
    task automatic t_reg_reset;
        dwr(6'h00, 8'h0b);
        cyc(4);
        reg_reset_n <= 1'b0;
        cyc(6);
        check("rate_rst", ch_rate, 8'h00);
        check("rail_rst", {6'h0, single_rail, codec_en}, 8'h00);
        reg_reset_n <= 1'b1;
        cyc(4);
        drd(6'h00, rd_q);
        check("global_rst", rd_q, 8'h00);
    endtask

    // main sequence
    initial
    begin
        cyc(20);
        rst <= 1'b0;
        cyc(6);
        t_hw_straps();
        t_hw_frame();
        t_host_regs();
        t_interrupt();
        t_reg_reset();
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
